// ===== rtl/ocf_fault_response.sv
`timescale 1ns/1ps
`default_nettype none
//
// Function
// - Each output holds a one-byte undercurrent response setting that resets to immediate shutdown, no retry.
// - Any undercurrent fault drives the alert line low and sets a status bit that only clear-faults clears.
// - Response code 10 disables the output at once and then follows the retry setting; 00 and 01 are unused.
// - Response code 11 keeps the output off only while the fault lasts and turns it back on afterwards.
// - Retry setting 000 keeps the output off until faults are cleared; 001 to 110 are unused.
// - Retry setting 111 restarts endlessly until commanded off, bias is lost or another fault shuts down.
// - Starts of successive restart attempts are spaced by (delay field plus one) times 35 ms.
// - An undercurrent fault sets the undercurrent status bit, not a generic one.
// - Down-slope sensing averages off-time samples after blanking against the average limits.
// - Up-slope sensing averages on-time samples after blanking against the average limits.
// - An average overcurrent trip sets the overcurrent bit and pulses avg_oc_trip_o for the overcurrent response.
// - An average undercurrent trip sets the undercurrent bit and calls the undercurrent response.
// - Each average limit is a 16-bit linear-11 value, mantissa times two to the exponent, amperes.
// - The average overcurrent limit loads at power-up from the strap-selected value.
// - The average undercurrent limit defaults to the negated strap-derived overcurrent limit.
// - Response setting and both limits are per output, readable, writable and write protected.
//
module ocf_fault_response
  import ocf_pkg::*;
#(
  parameter int NUM_OUT   = 2,
  parameter int RETRY_CYC = RETRY_UNIT_CYC,
  parameter int CNT_W     = 12
) (
  // clock and reset
  input  wire logic               ref_clk_i,
  input  wire logic               rst_i,
  // management command port
  input  wire logic               cmd_valid_i,
  input  wire ocf_cmd_s           cmd_i,
  input  wire logic               write_protect_i,
  output ocf_rsp_s                rsp_o,
  // pins
  input  wire logic [2:0]         cfg_strap_i,
  input  wire logic               control_pin_i,
  output logic                    alert_line_n_o,
  // device state
  input  wire logic               operation_on_i,
  input  wire logic               bias_ok_i,
  input  wire logic               slope_up_i,
  // per output conditions
  input  wire ocf_sample_s        sample_i       [NUM_OUT],
  input  wire logic [NUM_OUT-1:0] uc_limit_i,
  input  wire logic [NUM_OUT-1:0] other_fault_i,
  // per output results
  output logic [NUM_OUT-1:0]      output_enable_o,
  output logic [NUM_OUT-1:0]      uc_status_o,
  output logic [NUM_OUT-1:0]      oc_status_o,
  output logic [NUM_OUT-1:0]      avg_oc_trip_o
);

  typedef enum logic [2:0] {
    ST_OFF,
    ST_RUN,
    ST_HOLD,
    ST_LATCHED,
    ST_RETRY
  } ocf_state_e;

  localparam int TMR_W = $clog2(8 * RETRY_CYC + 1);

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [2:0] ctrl_sync;
  logic       ctrl_on;
  logic [2:0] strap_s1;
  logic [2:0] strap_s2;
  logic [2:0] strap_s3;
  logic [1:0] settle;
  logic       strap_done;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl_sync <= '0;
      ctrl_on   <= 1'b0;
    end else begin
      ctrl_sync <= {ctrl_sync[1:0], control_pin_i};
      if (ctrl_sync[1] == ctrl_sync[2]) begin
        ctrl_on <= ctrl_sync[2];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      strap_s1 <= '0;
      strap_s2 <= '0;
      strap_s3 <= '0;
    end else begin
      strap_s1 <= cfg_strap_i;
      strap_s2 <= strap_s1;
      strap_s3 <= strap_s2;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      settle <= '0;
    end else if (settle != 2'(STRAP_SETTLE)) begin
      settle <= settle + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // per output registers

  logic [7:0]  uc_resp  [NUM_OUT];
  logic [15:0] avg_oc   [NUM_OUT];
  logic [15:0] avg_uc   [NUM_OUT];
  logic        strap_load;
  logic        wr_ok;
  logic        hit;
  logic        clr;

  assign strap_load = !strap_done && settle == 2'(STRAP_SETTLE) && strap_s2 == strap_s3;
  assign hit   = cmd_i.code == CMD_UC_RESPONSE || cmd_i.code == CMD_AVG_OC_LIMIT ||
                 cmd_i.code == CMD_AVG_UC_LIMIT;
  assign wr_ok = cmd_valid_i && cmd_i.write && !write_protect_i && int'(cmd_i.page) < NUM_OUT;
  assign clr   = wr_ok && cmd_i.code == CMD_CLEAR_FAULTS;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      strap_done <= 1'b0;
    end else if (strap_load) begin
      strap_done <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    for (int p = 0; p < NUM_OUT; p++) begin
      if (rst_i) begin
        uc_resp[p] <= UC_RESPONSE_RESET;
        avg_oc[p]  <= '0;
        avg_uc[p]  <= '0;
      end else if (strap_load) begin
        avg_oc[p] <= STRAP_OC_LIMIT[strap_s3];
        avg_uc[p] <= lin11_negate(STRAP_OC_LIMIT[strap_s3]);
      end else if (wr_ok && int'(cmd_i.page) == p) begin
        case (cmd_i.code)
          CMD_UC_RESPONSE:  uc_resp[p] <= cmd_i.data[7:0];
          CMD_AVG_OC_LIMIT: avg_oc[p]  <= cmd_i.data;
          CMD_AVG_UC_LIMIT: avg_uc[p]  <= cmd_i.data;
          default: ;
        endcase
      end
    end
  end

  // read back, refusal of protected or unknown access
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rsp_o <= '0;
    end else begin
      rsp_o.valid <= cmd_valid_i;
      rsp_o.data  <= '0;
      rsp_o.error <= 1'b0;
      if (cmd_valid_i) begin
        if (int'(cmd_i.page) >= NUM_OUT || (cmd_i.write && write_protect_i)) begin
          rsp_o.error <= 1'b1;
        end else if (!hit && !(cmd_i.write && cmd_i.code == CMD_CLEAR_FAULTS)) begin
          rsp_o.error <= 1'b1;
        end else if (!cmd_i.write) begin
          case (cmd_i.code)
            CMD_UC_RESPONSE:  rsp_o.data <= {8'h00, uc_resp[cmd_i.page]};
            CMD_AVG_OC_LIMIT: rsp_o.data <= avg_oc[cmd_i.page];
            CMD_AVG_UC_LIMIT: rsp_o.data <= avg_uc[cmd_i.page];
            default:          rsp_o.error <= 1'b1;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // per output averaging and response

  logic run_req;

  assign run_req = ctrl_on && operation_on_i && bias_ok_i;

  for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
    logic             avg_oc_lvl;
    logic             avg_uc_lvl;
    logic             avg_done;
    logic             uc_present;
    logic             allowed;
    logic [1:0]       code;
    logic [2:0]       retry;
    logic [TMR_W-1:0] tmr;
    logic [TMR_W-1:0] spacing;
    ocf_state_e       state;
    ocf_state_e       next_state;

    ocf_avg_window #(
      .CNT_W (CNT_W)
    ) u_avg (
      .ref_clk_i  (ref_clk_i),
      .rst_i      (rst_i),
      .sample_i   (sample_i[g]),
      .slope_up_i (slope_up_i),
      .oc_thr_i   (lin11_to_fix(avg_oc[g])),
      .uc_thr_i   (lin11_to_fix(avg_uc[g])),
      .avg_oc_o   (avg_oc_lvl),
      .avg_uc_o   (avg_uc_lvl),
      .done_o     (avg_done)
    );

    assign uc_present = uc_limit_i[g] | avg_uc_lvl;
    assign allowed    = run_req && !other_fault_i[g];
    assign code       = uc_resp[g][RESP_CODE_HI:RESP_CODE_LO];
    assign retry      = uc_resp[g][RETRY_SEL_HI:RETRY_SEL_LO];
    assign spacing    = TMR_W'((int'(uc_resp[g][RETRY_DLY_HI:RETRY_DLY_LO]) + 1) * RETRY_CYC);

    always_comb begin
      next_state = state;
      case (state)
        ST_OFF: begin
          if (allowed) begin
            next_state = ST_RUN;
          end
        end
        ST_RUN: begin
          if (!allowed) begin
            next_state = ST_OFF;
          end else if (uc_present) begin
            if (code == RESP_WHILE_FAULT) begin
              next_state = ST_HOLD;
            end else if (code == RESP_SHUTDOWN && retry == RETRY_FOREVER) begin
              next_state = ST_RETRY;
            end else begin
              next_state = ST_LATCHED;
            end
          end
        end
        ST_HOLD: begin
          if (!allowed) begin
            next_state = ST_OFF;
          end else if (!uc_present) begin
            next_state = ST_RUN;
          end
        end
        ST_LATCHED: begin
          if (clr) begin
            next_state = allowed ? ST_RUN : ST_OFF;
          end
        end
        ST_RETRY: begin
          if (!allowed) begin
            next_state = ST_OFF;
          end else if (tmr >= spacing - TMR_W'(1)) begin
            next_state = ST_RUN;
          end
        end
        default: next_state = ST_OFF;
      endcase
    end

    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        state <= ST_OFF;
      end else begin
        state <= next_state;
      end
    end

    // time since the start of the last attempt
    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        tmr <= '0;
      end else if (next_state == ST_RUN && state != ST_RUN) begin
        tmr <= '0;
      end else if (!(&tmr)) begin
        tmr <= tmr + TMR_W'(1);
      end
    end

    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        output_enable_o[g] <= 1'b0;
      end else begin
        output_enable_o[g] <= next_state == ST_RUN;
      end
    end

    // sticky status, a new fault wins over the clear
    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        uc_status_o[g] <= 1'b0;
        oc_status_o[g] <= 1'b0;
      end else begin
        uc_status_o[g] <= uc_present | (uc_status_o[g] & !clr);
        oc_status_o[g] <= (avg_done & avg_oc_lvl) | (oc_status_o[g] & !clr);
      end
    end

    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        avg_oc_trip_o[g] <= 1'b0;
      end else begin
        avg_oc_trip_o[g] <= avg_done & avg_oc_lvl;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // alert line

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      alert_line_n_o <= 1'b1;
    end else begin
      alert_line_n_o <= !(|uc_status_o || |oc_status_o || |uc_limit_i);
    end
  end

endmodule
`default_nettype wire

// ===== shared/ocf_pkg.sv
package ocf_pkg;

  // command codes
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_UC_RESPONSE  = 8'hE6;
  localparam logic [7:0] CMD_AVG_OC_LIMIT = 8'hE7;
  localparam logic [7:0] CMD_AVG_UC_LIMIT = 8'hE8;

  // response setting layout
  localparam logic [7:0] UC_RESPONSE_RESET = 8'h80;
  localparam int         RESP_CODE_HI      = 7;
  localparam int         RESP_CODE_LO      = 6;
  localparam int         RETRY_SEL_HI      = 5;
  localparam int         RETRY_SEL_LO      = 3;
  localparam int         RETRY_DLY_HI      = 2;
  localparam int         RETRY_DLY_LO      = 0;
  localparam logic [1:0] RESP_SHUTDOWN     = 2'h2;
  localparam logic [1:0] RESP_WHILE_FAULT  = 2'h3;
  localparam logic [2:0] RETRY_NONE        = 3'h0;
  localparam logic [2:0] RETRY_FOREVER     = 3'h7;

  // linear-11 layout
  localparam int LIN_EXP_HI = 15;
  localparam int LIN_EXP_LO = 11;
  localparam int LIN_MAN_HI = 10;
  localparam int LIN_MAN_LO = 0;

  // sample scale: signed amperes with this many fraction bits
  localparam int SAMPLE_FRAC = 4;

  // timing
  localparam int CLK_HZ          = 10_000_000;
  localparam int RETRY_UNIT_MS   = 35;
  localparam int RETRY_UNIT_CYC  = RETRY_UNIT_MS * (CLK_HZ / 1000);
  localparam int STRAP_SETTLE    = 3;

  // strap-selected average overcurrent limits, exponent 0 (values arbitrary)
  localparam logic [15:0] STRAP_OC_LIMIT [8] = '{
    16'h000A, 16'h0014, 16'h001E, 16'h0028,
    16'h0032, 16'h003C, 16'h0046, 16'h0050
  };

  typedef struct packed {
    logic        write;
    logic [7:0]  code;
    logic        page;
    logic [15:0] data;
  } ocf_cmd_s;

  typedef struct packed {
    logic        valid;
    logic        error;
    logic [15:0] data;
  } ocf_rsp_s;

  typedef struct packed {
    logic              valid;
    logic signed [15:0] amps;
    logic              on_time;
    logic              blank;
  } ocf_sample_s;

  // linear-11 word to signed fixed point at the sample scale
  function automatic logic signed [31:0] lin11_to_fix(input logic [15:0] w);
    logic signed [5:0]  sh;
    logic signed [31:0] m;
    sh = 6'(signed'(w[LIN_EXP_HI:LIN_EXP_LO])) + 6'(SAMPLE_FRAC);
    m  = 32'(signed'(w[LIN_MAN_HI:LIN_MAN_LO]));
    if (sh >= 0) begin
      return m <<< sh;
    end
    return m >>> (-sh);
  endfunction

  // negate the mantissa, keep the exponent
  function automatic logic [15:0] lin11_negate(input logic [15:0] w);
    return {w[LIN_EXP_HI:LIN_EXP_LO], 11'(-w[LIN_MAN_HI:LIN_MAN_LO])};
  endfunction

endpackage

// ===== rtl/ocf_avg_window.sv
`timescale 1ns/1ps
`default_nettype none
module ocf_avg_window
  import ocf_pkg::*;
#(
  parameter int CNT_W = 12
) (
  // clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                rst_i,
  // samples and mode
  input  wire ocf_sample_s         sample_i,
  input  wire logic                slope_up_i,
  // thresholds at sample scale
  input  wire logic signed [31:0]  oc_thr_i,
  input  wire logic signed [31:0]  uc_thr_i,
  // results
  output logic                     avg_oc_o,
  output logic                     avg_uc_o,
  output logic                     done_o
);

  logic                    in_window;
  logic                    was_window;
  logic signed [27:0]      sum;
  logic        [CNT_W-1:0] cnt;
  logic signed [47:0]      sum_w;
  logic signed [47:0]      oc_lim;
  logic signed [47:0]      uc_lim;

  // off-time for down-slope, on-time for up-slope
  assign in_window = slope_up_i ? sample_i.on_time : !sample_i.on_time;
  assign sum_w  = 48'(sum);
  assign oc_lim = 48'(oc_thr_i) * 48'(signed'({1'b0, cnt}));
  assign uc_lim = 48'(uc_thr_i) * 48'(signed'({1'b0, cnt}));

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      was_window <= 1'b0;
    end else begin
      was_window <= in_window;
    end
  end

  // accumulate outside blanking; restart at each window start
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sum <= '0;
      cnt <= '0;
    end else if (in_window && !was_window) begin
      sum <= (sample_i.valid && !sample_i.blank) ? 28'(sample_i.amps) : '0;
      cnt <= (sample_i.valid && !sample_i.blank) ? CNT_W'(1) : '0;
    end else if (in_window && sample_i.valid && !sample_i.blank && !(&cnt)) begin
      sum <= sum + 28'(sample_i.amps);
      cnt <= cnt + CNT_W'(1);
    end
  end

  // mean compared without division: sum against limit times count
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      avg_oc_o <= 1'b0;
      avg_uc_o <= 1'b0;
      done_o   <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (was_window && !in_window && cnt != '0) begin
        avg_oc_o <= sum_w > oc_lim;
        avg_uc_o <= sum_w < uc_lim;
        done_o   <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ===== tb/ocf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ocf_host_model
  import ocf_pkg::*;
(
  // clock
  input  wire logic     ref_clk_i,
  // command port
  output var  logic     cmd_valid_o,
  output var  ocf_cmd_s cmd_o,
  input  wire ocf_rsp_s rsp_i
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_o = '0;
  end
  // request held to the taking edge, answer read one cycle on
  task automatic xfer(input logic w, input logic [7:0] c, input logic p,
                      input logic [15:0] d, output ocf_rsp_s r);
    @(posedge ref_clk_i);
    cmd_valid_o <= 1'b1;
    cmd_o <= '{write: w, code: c, page: p, data: d};
    @(posedge ref_clk_i);
    cmd_valid_o <= 1'b0;
    cmd_o.data <= ~d;
    @(posedge ref_clk_i);
    r = rsp_i;
  endtask
endmodule
`default_nettype wire

// ===== tb/ocf_fault_response_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ocf_fault_response_assertions
  import ocf_pkg::*;
#(
  parameter int NUM_OUT = 2
) (
  // clock and reset
  input wire logic               ref_clk_i,
  input wire logic               rst_i,
  // command port
  input wire logic               cmd_valid_i,
  input wire ocf_cmd_s           cmd_i,
  input wire logic               write_protect_i,
  input wire ocf_rsp_s           rsp_o,
  // pins and state
  input wire logic               alert_line_n_o,
  input wire logic               bias_ok_i,
  // per output
  input wire logic [NUM_OUT-1:0] uc_limit_i,
  input wire logic [NUM_OUT-1:0] other_fault_i,
  input wire logic [NUM_OUT-1:0] output_enable_o,
  input wire logic [NUM_OUT-1:0] uc_status_o,
  input wire logic [NUM_OUT-1:0] oc_status_o,
  input wire logic [NUM_OUT-1:0] avg_oc_trip_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic clr;
  assign clr = cmd_valid_i && cmd_i.write && !write_protect_i && cmd_i.code == CMD_CLEAR_FAULTS;
  sequence uc_hit;
    uc_limit_i[0] && output_enable_o[0];
  endsequence
  sequence off_flagged;
    !output_enable_o[0] && uc_status_o[0];
  endsequence
  a_uc_shutdown_alert: assert property (uc_hit |=> off_flagged ##1 !alert_line_n_o)
    else $error("uc fault did not shut output and alert");
  a_uc_status_set: assert property (uc_limit_i[1] |=> uc_status_o[1])
    else $error("uc status not set");
  a_status_sticky: assert property (uc_status_o[0] && !clr |=> uc_status_o[0])
    else $error("uc status dropped without clear");
  a_alert_on_status: assert property ((|uc_status_o) |=> !alert_line_n_o)
    else $error("alert high while status set");
  a_rsp_next: assert property (cmd_valid_i |=> rsp_o.valid)
    else $error("no answer to command");
  a_rsp_quiet: assert property (!cmd_valid_i |=> !rsp_o.valid)
    else $error("answer without command");
  a_protect_refused: assert property (cmd_valid_i && cmd_i.write && write_protect_i |=> rsp_o.error)
    else $error("protected write accepted");
  a_bias_off: assert property (!bias_ok_i |=> output_enable_o == '0)
    else $error("output on without bias");
  a_other_off: assert property (other_fault_i[0] |=> !output_enable_o[0])
    else $error("output on during other fault");
  a_oc_trip_status: assert property (avg_oc_trip_o[0] |-> oc_status_o[0] ##1 !avg_oc_trip_o[0])
    else $error("average trip without oc status");
endmodule
bind ocf_fault_response ocf_fault_response_assertions #(.NUM_OUT(NUM_OUT)) u_chk (
  .ref_clk_i, .rst_i, .cmd_valid_i, .cmd_i, .write_protect_i, .rsp_o, .alert_line_n_o,
  .bias_ok_i, .uc_limit_i, .other_fault_i, .output_enable_o, .uc_status_o, .oc_status_o,
  .avg_oc_trip_o);
`default_nettype wire

// ===== tb/test_output_current_fault_response.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module test_output_current_fault_response import ocf_pkg::*;;
  localparam int NO = 2;
  localparam int RC = 10;
  logic              ref_clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              cmd_valid;
  ocf_cmd_s          cmd;
  ocf_rsp_s          rsp;
  ocf_rsp_s          r;
  logic              wp = 1'b0;
  logic [2:0]        strap = 3'h5;
  logic              ctl = 1'b0;
  logic              opon = 1'b0;
  logic              bias = 1'b1;
  logic              slope = 1'b0;
  ocf_sample_s       smp [NO];
  logic [NO-1:0]     ucl = '0;
  logic [NO-1:0]     oth = '0;
  logic [NO-1:0]     en, ucs, ocs, trip;
  logic              alert_n;
  int                fails = 0;
  int                check_count = 0;
  int                trips = 0;
  int                rg [3][NO];
  int unsigned       rs = 60;
  int                cs [4][5] = '{'{0, 50, 1, 0, 0}, '{0, 0, 5, 1, 0}, '{1, 50, 5, 1, 0},
                                   '{1, 50, -5, 0, 1}};
  always #50 ref_clk_i = ~ref_clk_i;
  // averaged overcurrent trip pulses seen on output 0
  always @(posedge ref_clk_i) begin
    if (trip[0] === 1'b1) trips++;
  end
  ocf_host_model u_host (.ref_clk_i, .cmd_valid_o(cmd_valid), .cmd_o(cmd), .rsp_i(rsp));
  ocf_fault_response #(.NUM_OUT(NO), .RETRY_CYC(RC)) u_ocf_fault_response (
    .ref_clk_i, .rst_i, .cmd_valid_i(cmd_valid), .cmd_i(cmd), .write_protect_i(wp),
    .rsp_o(rsp), .cfg_strap_i(strap), .control_pin_i(ctl), .alert_line_n_o(alert_n),
    .operation_on_i(opon), .bias_ok_i(bias), .slope_up_i(slope), .sample_i(smp),
    .uc_limit_i(ucl), .other_fault_i(oth), .output_enable_o(en), .uc_status_o(ucs),
    .oc_status_o(ocs), .avg_oc_trip_o(trip));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic int unsigned xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function automatic int neg_lin(input int w);
    int m;
    m = w & 32'h7FF;
    if (m >= 1024) m -= 2048;
    return (w & 32'hF800) | (-m & 32'h7FF);
  endfunction
  task automatic tally_and_finish();
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic rd(input logic [7:0] c, input int p, input int e);
    u_host.xfer(1'b0, c, p[0], 16'h0000, r);
    `CHK("read valid", 1'b1, r.valid)
    `CHK("read error", 1'b0, r.error)
    `CHK("read data", e[15:0], r.data)
  endtask
  task automatic wr(input logic [7:0] c, input int p, input int d, input logic e);
    u_host.xfer(1'b1, c, p[0], d[15:0], r);
    `CHK("write error", e, r.error)
    if (!e && c != CMD_CLEAR_FAULTS) rg[c - CMD_UC_RESPONSE][p] = (c == CMD_UC_RESPONSE) ? d & 32'hFF : d;
  endtask
  task automatic wait_en(input int b, input logic v, input int lim);
    int k;
    k = 0;
    while (en[b] !== v && k < lim) begin
      @(posedge ref_clk_i);
      k++;
    end
    `CHK("enable wait", v, en[b])
    if (en[b] !== v) tally_and_finish();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    smp[0] = '0;
    smp[1] = '0;
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
    for (int p = 0; p < NO; p++) begin
      rg[0][p] = 32'h80;
      rg[1][p] = STRAP_OC_LIMIT[strap];
      rg[2][p] = neg_lin(rg[1][p]);
      rd(CMD_UC_RESPONSE, p, rg[0][p]);
      rd(CMD_AVG_OC_LIMIT, p, rg[1][p]);
      rd(CMD_AVG_UC_LIMIT, p, rg[2][p]);
    end
    for (int i = 0; i < 9; i++) begin
      wp <= i[2];
      wr(CMD_UC_RESPONSE + 8'(i % 3), i % NO, xs() & 32'hFFFF, i[2]);
      rd(CMD_UC_RESPONSE + 8'(i % 3), i % NO, rg[i % 3][i % NO]);
    end
    wp <= 1'b0;
    u_host.xfer(1'b0, CMD_CLEAR_FAULTS, 1'b0, 16'h0000, r);
    `CHK("read clear", 1'b1, r.error)
    u_host.xfer(1'b1, 8'hE9, 1'b0, 16'h1234, r);
    `CHK("unknown code", 1'b1, r.error)
    wr(CMD_UC_RESPONSE, 0, 32'h80, 1'b0);
    ctl <= 1'b1;
    opon <= 1'b1;
    wait_en(0, 1'b1, 20);
    wait_en(1, 1'b1, 100);
    ucl[0] <= 1'b1;
    @(posedge ref_clk_i);
    ucl[0] <= 1'b0;
    repeat (20) @(posedge ref_clk_i);
    `CHK("latched off", 2'b10, en)
    `CHK("uc status", 2'b01, ucs)
    `CHK("alert", 1'b0, alert_n)
    ucl[1] <= 1'b1;
    @(posedge ref_clk_i);
    ucl[1] <= 1'b0;
    wr(CMD_CLEAR_FAULTS, 0, 0, 1'b0);
    `CHK("cleared", 2'b00, ucs)
    wait_en(0, 1'b1, 20);
    wr(CMD_UC_RESPONSE, 0, 32'hC0, 1'b0);
    ucl[0] <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    `CHK("off while fault", 1'b0, en[0])
    ucl[0] <= 1'b0;
    wait_en(0, 1'b1, 4);
    for (int j = 0; j < 2; j++) begin
      int t;
      wr(CMD_UC_RESPONSE, 0, 32'hB8 + 7 * j, 1'b0);
      ucl[0] <= 1'b1;
      wait_en(0, 1'b0, 4);
      wait_en(0, 1'b1, 100);
      t = 0;
      @(posedge ref_clk_i);
      while (en[0] !== 1'b1 && t < 200) begin
        @(posedge ref_clk_i);
        t++;
      end
      `CHK("retry gap", (7 * j + 1) * RC, t + 1)
      if (j == 0) bias <= 1'b0;
      else oth[0] <= 1'b1;
      repeat (100) @(posedge ref_clk_i);
      `CHK("stopped", 1'b0, en[0])
      bias <= 1'b1;
      oth <= '0;
      ucl <= '0;
      wr(CMD_CLEAR_FAULTS, 0, 0, 1'b0);
      wait_en(0, 1'b1, 100);
    end
    wr(CMD_UC_RESPONSE, 0, 32'hC0, 1'b0);
    wr(CMD_AVG_OC_LIMIT, 0, 32'h0002, 1'b0);
    wr(CMD_AVG_UC_LIMIT, 0, 32'h07FE, 1'b0);
    for (int c = 0; c < 4; c++) begin
      slope <= cs[c][0][0];
      smp[0] <= '{1'b0, 16'h0000, !cs[c][0][0], 1'b0};
      repeat (2) @(posedge ref_clk_i);
      wr(CMD_CLEAR_FAULTS, 0, 0, 1'b0);
      smp[0] <= '{1'b1, 16'(cs[c][1] * 16), cs[c][0][0], 1'b1};
      for (int s = 0; s < 3; s++) begin
        @(posedge ref_clk_i);
        smp[0] <= '{1'b1, 16'(cs[c][2] * 16), cs[c][0][0], 1'b0};
      end
      @(posedge ref_clk_i);
      smp[0] <= '{1'b0, 16'h0000, !cs[c][0][0], 1'b0};
      repeat (5) @(posedge ref_clk_i);
      `CHK("avg oc", cs[c][3][0], ocs[0])
      `CHK("avg uc", cs[c][4][0], ucs[0])
    end
    `CHK("avg trips", 2, trips)
    tally_and_finish();
  end
endmodule
`default_nettype wire
